/* design/urxbs_pkg.sv */
package urxbs_pkg;

  // ---------------------------------------------------------------
  // register map and field positions
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 2;
  localparam logic [1:0]  ADDR_STATUS  = 2'h0;
  localparam logic [1:0]  ADDR_CTRL_B  = 2'h1;
  localparam logic [1:0]  ADDR_CTRL_C  = 2'h2;
  localparam logic [1:0]  ADDR_DATA    = 2'h3;

  localparam int ST_RXC   = 7;
  localparam int ST_FE    = 4;
  localparam int ST_DOR   = 3;
  localparam int ST_UPE   = 2;

  localparam int CB_RXCIE = 7;
  localparam int CB_RXEN  = 4;
  localparam int CB_SIZE2 = 2;
  localparam int CB_RXB9  = 1;
  localparam int CB_TXB9  = 0;

  localparam int CC_PM_HI = 5;
  localparam int CC_PM_LO = 4;
  localparam int CC_STOP  = 3;
  localparam int CC_SIZE1 = 2;
  localparam int CC_SIZE0 = 1;

  localparam logic [2:0] SIZE_RST  = 3'h3;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] SIZE_BASE = 4'h5;

  // ---------------------------------------------------------------
  // fifo entry layout
  // ---------------------------------------------------------------
  localparam int E_B9  = 8;
  localparam int E_FE  = 9;
  localparam int E_DOR = 10;
  localparam int E_UPE = 11;
  localparam int E_W   = 12;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int BAUD_W            = 16;
  localparam int CLKS_PER_BIT_DFLT = 16;

  typedef enum logic [2:0] {
    URXBS_IDLE  = 3'h0,
    URXBS_START = 3'h1,
    URXBS_DATA  = 3'h3,
    URXBS_PAR   = 3'h2,
    URXBS_STOP  = 3'h6
  } urxbs_state_t;

  typedef struct packed {
    logic              syn1;
    logic              syn2;
    logic [7:0]        rdata;
    logic              irq;
    logic              pin_own;
    logic              rxcie;
    logic              rxen;
    logic              txb9;
    logic              pm_hi;
    logic              pm_lo;
    logic              stop_sel;
    logic [2:0]        size;
    urxbs_state_t      st;
    logic [BAUD_W-1:0] baud;
    logic [3:0]        bitidx;
    logic [8:0]        shreg;
    logic              par;
    logic              hold_v;
    logic [E_W-1:0]    hold;
    logic              ovr;
    logic [E_W-1:0]    ent0;
    logic [E_W-1:0]    ent1;
    logic              rdp;
    logic [1:0]        cnt;
  } urxbs_regs_t;

  // synchroniser starts at the idle line level, so no false start follows reset
  localparam urxbs_regs_t URXBS_RST = '{syn1: 1'b1, syn2: 1'b1, size: SIZE_RST,
                                        st: URXBS_IDLE, default: '0};

endpackage : urxbs_pkg

/* design/urxbs_top.sv */
// Notes on behaviour
// - ninth bit sits in fifo; data read advances fifo to next entry
// - receive-complete reads one when fifo holds any unread character
// - clearing receiver enable flushes fifo and clears receive-complete
// - interrupt request is a level while interrupt enable, global enable and receive-complete are set
// - error flags stored per entry; status shows oldest entry
// - writes to status never change the error flags
// - error flags raise no interrupt
// - frame error is one when first stop bit sampled zero
// - only first stop bit checked; stop count setting irrelevant
// - overrun when start seen, fifo full and a frame waiting
// - overrun cleared when a frame moves into the fifo
// - parity checked only when high mode bit set; low bit picks odd
// - parity result stored in the entry with its character
// - parity flag valid for oldest entry until data read
// - parity flag reads zero while checking is off
// - disabling stops reception at once and releases the pin
// - unused upper data bits read zero for short characters
// - frame moves into fifo once first stop bit received
// - enabling gives the pin to the receiver
`timescale 1ns/100ps
module urxbs_top
  import urxbs_pkg::*;
#(
  parameter int CLKS_PER_BIT = CLKS_PER_BIT_DFLT
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // serial line and pin ownership
  input  wire logic              serial_input_pin,
  output logic                   serial_pin_override,
  // interrupt request
  input  wire logic              global_irq_enable,
  output logic                   rx_complete_irq_req
);

  localparam logic [BAUD_W-1:0] BIT_LAST  = BAUD_W'(CLKS_PER_BIT - 1);
  localparam logic [BAUD_W-1:0] HALF_LAST = BAUD_W'(CLKS_PER_BIT / 2 - 1);

  urxbs_regs_t    q;
  urxbs_regs_t    next_q;
  logic [E_W-1:0] head;
  logic [E_W-1:0] frame;
  logic [3:0]     nbits;
  logic           rx;
  logic           pop;
  logic           push;
  logic           wp;
  logic           started;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q  = q;
    pop     = 1'b0;
    push    = 1'b0;
    started = 1'b0;
    frame   = '0;
    rx      = q.syn2;
    head    = q.rdp ? q.ent1 : q.ent0;
    wp      = q.rdp ^ (q.cnt == 2'h1);
    nbits   = (q.size == SIZE_NINE) ? 4'h9 : SIZE_BASE + {2'h0, q.size[1:0]};

    // pin synchroniser
    next_q.syn1 = serial_input_pin;
    next_q.syn2 = q.syn1;

    // register port
    next_q.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ADDR_STATUS) begin
        next_q.rdata[ST_RXC] = (q.cnt != 2'h0);
        next_q.rdata[ST_FE]  = (q.cnt != 2'h0) & head[E_FE];
        next_q.rdata[ST_DOR] = (q.cnt != 2'h0) & head[E_DOR];
        next_q.rdata[ST_UPE] = (q.cnt != 2'h0) & head[E_UPE] & q.pm_hi;
      end else if (reg_addr == ADDR_CTRL_B) begin
        next_q.rdata[CB_RXCIE] = q.rxcie;
        next_q.rdata[CB_RXEN]  = q.rxen;
        next_q.rdata[CB_SIZE2] = q.size[2];
        next_q.rdata[CB_RXB9]  = (q.cnt != 2'h0) & head[E_B9];
        next_q.rdata[CB_TXB9]  = q.txb9;
      end else if (reg_addr == ADDR_CTRL_C) begin
        next_q.rdata[CC_PM_HI] = q.pm_hi;
        next_q.rdata[CC_PM_LO] = q.pm_lo;
        next_q.rdata[CC_STOP]  = q.stop_sel;
        next_q.rdata[CC_SIZE1] = q.size[1];
        next_q.rdata[CC_SIZE0] = q.size[0];
      end else begin
        // empty read returns zero and leaves the fifo alone
        if (q.cnt != 2'h0) begin
          next_q.rdata = head[7:0];
          pop          = 1'b1;
        end
      end
    end
    // status writes are dropped: its flags live in the fifo
    if (reg_wr) begin
      if (reg_addr == ADDR_CTRL_B) begin
        next_q.rxcie   = reg_wdata[CB_RXCIE];
        next_q.rxen    = reg_wdata[CB_RXEN];
        next_q.size[2] = reg_wdata[CB_SIZE2];
        next_q.txb9    = reg_wdata[CB_TXB9];
      end else if (reg_addr == ADDR_CTRL_C) begin
        next_q.pm_hi    = reg_wdata[CC_PM_HI];
        next_q.pm_lo    = reg_wdata[CC_PM_LO];
        next_q.stop_sel = reg_wdata[CC_STOP];
        next_q.size[1]  = reg_wdata[CC_SIZE1];
        next_q.size[0]  = reg_wdata[CC_SIZE0];
      end
    end

    // waiting frame into fifo; pop in the same cycle does not free room,
    // which delays the move by one cycle, or loses the frame to overrun if a start is confirmed in that cycle
    if (q.hold_v && (q.cnt != FIFO_DEPTH)) begin
      push = 1'b1;
      next_q.hold_v = 1'b0;
      next_q.ovr    = 1'b0;
      if (wp) begin
        next_q.ent1 = q.hold | (E_W'(q.ovr) << E_DOR);
      end else begin
        next_q.ent0 = q.hold | (E_W'(q.ovr) << E_DOR);
      end
    end
    if (pop) begin
      next_q.rdp = ~q.rdp;
    end
    next_q.cnt = q.cnt + {1'b0, push} - {1'b0, pop};

    // receiver
    case (q.st)
      URXBS_IDLE: begin
        if (!rx) begin
          next_q.st   = URXBS_START;
          next_q.baud = HALF_LAST;
        end
      end
      URXBS_START: begin
        if (q.baud != '0) begin
          next_q.baud = q.baud - 1'b1;
        end else if (rx) begin
          next_q.st = URXBS_IDLE;
        end else begin
          started       = 1'b1;
          next_q.st     = URXBS_DATA;
          next_q.baud   = BIT_LAST;
          next_q.bitidx = 4'h0;
          next_q.shreg  = 9'h000;
          if ((q.cnt == FIFO_DEPTH) && q.hold_v) begin
            next_q.ovr    = 1'b1;
            next_q.hold_v = 1'b0;
          end
        end
      end
      URXBS_DATA: begin
        if (q.baud != '0) begin
          next_q.baud = q.baud - 1'b1;
        end else begin
          next_q.shreg[q.bitidx] = rx;
          next_q.baud            = BIT_LAST;
          if (q.bitidx == nbits - 4'h1) begin
            next_q.st = q.pm_hi ? URXBS_PAR : URXBS_STOP;
          end else begin
            next_q.bitidx = q.bitidx + 4'h1;
          end
        end
      end
      URXBS_PAR: begin
        if (q.baud != '0) begin
          next_q.baud = q.baud - 1'b1;
        end else begin
          next_q.par  = rx;
          next_q.baud = BIT_LAST;
          next_q.st   = URXBS_STOP;
        end
      end
      URXBS_STOP: begin
        // only the first stop bit is looked at
        if (q.baud != '0) begin
          next_q.baud = q.baud - 1'b1;
        end else begin
          frame[8:0]    = q.shreg;
          frame[E_FE]   = ~rx;
          frame[E_UPE]  = q.pm_hi & (^q.shreg ^ q.par ^ q.pm_lo);
          next_q.hold   = frame;
          next_q.hold_v = 1'b1;
          next_q.st     = URXBS_IDLE;
        end
      end
      default: begin
        next_q.st = URXBS_IDLE;
      end
    endcase

    // disabled receiver: no frame, no fifo
    if (!q.rxen) begin
      next_q.st     = URXBS_IDLE;
      next_q.hold_v = 1'b0;
      next_q.ovr    = 1'b0;
      next_q.cnt    = 2'h0;
      next_q.rdp    = 1'b0;
    end

    next_q.pin_own = q.rxen;
    // level request, errors play no part
    next_q.irq = q.rxcie & (q.cnt != 2'h0) & global_irq_enable;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= URXBS_RST;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata           = q.rdata;
  assign serial_pin_override = q.pin_own;
  assign rx_complete_irq_req = q.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  rxc_status_a: assert property (
    reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[ST_RXC] == ($past(q.cnt) != 2'h0))
    else $error("receive-complete does not match fifo fill");

  flush_off_a: assert property (
    !q.rxen |=> q.cnt == 2'h0 && !q.hold_v)
    else $error("fifo not flushed while receiver disabled");

  irq_level_a: assert property (
    q.rxcie && q.cnt != 2'h0 && global_irq_enable |=> rx_complete_irq_req)
    else $error("interrupt request missing");

  irq_cause_a: assert property (
    rx_complete_irq_req |-> $past(q.cnt) != 2'h0 && $past(q.rxcie))
    else $error("interrupt request without unread data");

  pop_once_a: assert property (
    reg_rd && reg_addr == ADDR_DATA && q.cnt != 2'h0 && !push && q.rxen
    |=> q.cnt == $past(q.cnt) - 2'h1 && q.rdp != $past(q.rdp))
    else $error("data read did not advance fifo");

  empty_read_a: assert property (
    reg_rd && reg_addr == ADDR_DATA && q.cnt == 2'h0 && !push && q.rxen
    |=> q.cnt == 2'h0 && $stable(q.rdp) && reg_rdata == 8'h00)
    else $error("empty data read disturbed fifo");

  depth_max_a: assert property (
    q.cnt <= FIFO_DEPTH)
    else $error("fifo count above depth");

  flags_ro_a: assert property (
    reg_wr && reg_addr == ADDR_STATUS && !push |=> $stable(q.ent0) && $stable(q.ent1))
    else $error("status write changed fifo flags");

  upe_off_a: assert property (
    reg_rd && reg_addr == ADDR_STATUS && !q.pm_hi |=> !reg_rdata[ST_UPE])
    else $error("parity flag set while checking off");

  overrun_a: assert property (
    started && q.cnt == FIFO_DEPTH && q.hold_v && q.rxen |=> q.ovr && !q.hold_v)
    else $error("overrun not flagged");

  ovr_clear_a: assert property (
    push && q.rxen |=> !q.ovr || $past(started))
    else $error("overrun not cleared on transfer");

  pin_own_a: assert property (
    $fell(q.rxen) |=> !serial_pin_override ##0 q.st == URXBS_IDLE)
    else $error("pin not released on disable");

  // frame capture: stop and parity handling at the end of a frame
  fe_store_a: assert property (
    q.st == URXBS_STOP && q.baud == '0 && q.rxen |=> q.hold_v && q.hold[E_FE] == !$past(q.syn2))
    else $error("frame error not stored from stop sample");

  par_off_a: assert property (
    q.st == URXBS_DATA && q.baud == '0 && q.bitidx == nbits - 4'h1 && !q.pm_hi && q.rxen
    |=> q.st == URXBS_STOP)
    else $error("parity bit expected while checking off");

  upe_clear_a: assert property (
    q.st == URXBS_STOP && q.baud == '0 && !q.pm_hi |=> !q.hold[E_UPE])
    else $error("parity error stored while checking off");

  push_move_a: assert property (
    q.hold_v && q.cnt != FIFO_DEPTH && q.rxen |=> q.cnt != 2'h0)
    else $error("waiting frame not moved into fifo");

  irq_mask_a: assert property (
    !global_irq_enable |=> !rx_complete_irq_req)
    else $error("interrupt request while globally masked");

  irq_empty_a: assert property (
    q.cnt == 2'h0 |=> !rx_complete_irq_req)
    else $error("interrupt request with empty fifo");

  empty_status_a: assert property (
    reg_rd && reg_addr == ADDR_STATUS && q.cnt == 2'h0 |=> reg_rdata == 8'h00)
    else $error("status not clear with empty fifo");

  rxb9_a: assert property (
    reg_rd && reg_addr == ADDR_CTRL_B && q.cnt != 2'h0 |=> reg_rdata[CB_RXB9] == $past(head[E_B9]))
    else $error("ninth bit does not show oldest entry");

  abort_a: assert property (
    !q.rxen |=> q.st == URXBS_IDLE)
    else $error("reception goes on while disabled");

  pin_take_a: assert property (
    q.rxen |=> serial_pin_override)
    else $error("pin not taken while enabled");

  dor_entry_a: assert property (
    push && q.ovr && !wp |=> q.ent0[E_DOR])
    else $error("overrun not stored with next entry");

  shreg_clear_a: assert property (
    started && q.rxen |=> q.shreg == 9'h000)
    else $error("shift register not cleared at start");

  fifo_full_c: cover property (q.cnt == FIFO_DEPTH && q.hold_v);
  overrun_c: cover property (started && q.cnt == FIFO_DEPTH && q.hold_v);
  parity_err_c: cover property (push && q.hold[E_UPE]);
  frame_err_c: cover property (push && q.hold[E_FE]);
  nine_bit_c: cover property (push && q.hold[E_B9]);

endmodule : urxbs_top

/* bench/urxbs_tx_model.sv */
`timescale 1ns/100ps
module urxbs_tx_model #(
  parameter int CPB = 8
) (
  // clock
  input  wire logic sys_clk,
  // serial line
  output logic      line
);
  initial line = 1'b1;
  // --------
  // frame sender
  // --------
  // line idles high between frames, so no stale bit is left on it
  task automatic send_frame(input logic [8:0] d, input int nb, input bit pen,
                            input bit pb, input bit sv);
    bit q[$];
    q.push_back(1'b0);
    for (int i = 0; i < nb; i++) q.push_back(d[i]);
    if (pen) q.push_back(pb);
    q.push_back(sv);
    foreach (q[i]) begin
      line <= q[i];
      repeat (CPB) @(posedge sys_clk);
    end
    line <= 1'b1;
    repeat (CPB) @(posedge sys_clk);
  endtask
endmodule // urxbs_tx_model

/* bench/urxbs_top_tb.sv */
`timescale 1ns/100ps
module urxbs_top_tb;
  import urxbs_pkg::*;
  localparam int CPB = 8;
  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic           gie = 1'b0;
  logic [1:0]     reg_addr = '0;
  logic [7:0]     reg_wdata = '0;
  logic [7:0]     reg_rdata;
  logic [7:0]     d;
  logic           line;
  logic           ovr;
  logic           irq;
  logic [2:0]     sz;
  logic [E_W-1:0] exq[$];
  int             num_errors = 0;
  int             compares = 0;
  int             seed;
  int             nb;
  int             n;
  bit             pen;
  bit             podd;

  always #2 sys_clk = ~sys_clk;

  urxbs_tx_model #(.CPB(CPB)) tx_i (.sys_clk(sys_clk), .line(line));
  urxbs_top #(.CLKS_PER_BIT(CPB)) urxbs_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_input_pin(line),
    .serial_pin_override(ovr), .global_irq_enable(gie),
    .rx_complete_irq_req(irq));

  // --------
  // helpers
  // --------
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic cfg(input logic [7:0] cb, input logic [7:0] cc);
    wr(ADDR_CTRL_B, cb);
    wr(ADDR_CTRL_C, cc);
    pen = cc[CC_PM_HI];
    podd = cc[CC_PM_LO];
    nb = ({cb[CB_SIZE2], cc[2:1]} == SIZE_NINE) ? 9 : cc[2:1] + 5;
  endtask

  // expected entry kept only when the frame should reach the fifo
  task automatic send(input bit sv, input bit bad, input bit keep, input bit dor);
    logic [8:0] v;
    bit p;
    v = 9'($random(seed)) & ((9'h1 << nb) - 9'h1);
    p = ^v ^ podd ^ bad;
    if (keep) exq.push_back({bad & pen, dor, ~sv, v[8] & (nb == 9), v[7:0]});
    tx_i.send_frame(v, nb, pen, p, sv);
  endtask

  // status and ninth bit first, data last
  task automatic get_char();
    logic [7:0] s, b, v;
    logic [E_W-1:0] e;
    e = exq.pop_front();
    rd(ADDR_STATUS, s);
    rd(ADDR_CTRL_B, b);
    rd(ADDR_DATA, v);
    chk(s & 8'h9c, {1'b1, 2'b0, e[E_FE], e[E_DOR], e[E_UPE], 2'b0});
    chk(b[CB_RXB9], e[E_B9]);
    chk(v, e[7:0]);
  endtask

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  // --------
  // main sequence
  // --------
  initial begin
    seed = 32'hd448cd0d;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL_C, d);
    chk(d, 8'h06);
    rd(ADDR_STATUS, d);
    chk(d & 8'h9c, 8'h00);
    cfg(8'h10, 8'h0e);
    chk(ovr, 1'b1);
    send(1'b1, 1'b0, 1'b1, 1'b0);
    send(1'b0, 1'b0, 1'b1, 1'b0);
    chk(irq, 1'b0);
    get_char();
    wr(ADDR_STATUS, 8'he3);
    get_char();
    rd(ADDR_DATA, d);
    chk(d, 8'h00);
    rd(ADDR_STATUS, d);
    chk(d & 8'h9c, 8'h00);
    // overrun: each waiting frame is lost at the next start; last one carries the flag
    for (int i = 0; i < 5; i++) send(1'b1, 1'b0, i < 2 || i == 4, i == 4);
    for (int i = 0; i < 3; i++) get_char();
    send(1'b1, 1'b0, 1'b1, 1'b0);
    get_char();
    for (int m = 0; m < 4; m++) begin
      cfg(8'h10, {2'b0, m[1:0], 4'h6});
      send(1'b1, 1'b1, 1'b1, 1'b0);
      send(1'b1, 1'b0, 1'b1, 1'b0);
      get_char();
      get_char();
    end
    for (int k = 0; k < 5; k++) begin
      sz = (k == 4) ? SIZE_NINE : 3'(k);
      cfg(8'h10 | {5'h0, sz[2], 2'h0}, {5'h0, sz[1:0], 1'b0});
      send(1'b1, 1'b0, 1'b1, 1'b0);
      get_char();
    end
    cfg(8'h90, 8'h06);
    gie <= 1'b1;
    send(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b1);
    gie <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    gie <= 1'b1;
    get_char();
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    // software flush: read data until receive-complete clears
    send(1'b1, 1'b0, 1'b0, 1'b0);
    send(1'b1, 1'b0, 1'b0, 1'b0);
    n = 0;
    rd(ADDR_STATUS, d);
    while (d[ST_RXC] && n < 4) begin
      rd(ADDR_DATA, d);
      rd(ADDR_STATUS, d);
      n++;
    end
    chk(12'(n), 12'h002);
    send(1'b1, 1'b0, 1'b1, 1'b0);
    send(1'b1, 1'b0, 1'b1, 1'b0);
    wr(ADDR_CTRL_B, 8'h80);
    rd(ADDR_STATUS, d);
    chk(d[ST_RXC], 1'b0);
    chk(ovr, 1'b0);
    chk(irq, 1'b0);
    exq.delete();
    cfg(8'h10, 8'h06);
    rd(ADDR_DATA, d);
    chk(d, 8'h00);
    print_verdict();
  end
endmodule // urxbs_top_tb
